// *** core/can_transceiver_status_flags.v ***
// Transceiver state bits and latched fault flags behind an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "can_flags_defines.vh"

module can_transceiver_status_flags #(
  parameter NUM_FLAGS = `NFLAGS
) (
  // Clock and reset
  input wire sysClk,
  input wire rst_b,
  // Fault and event conditions from the analog front end (asynchronous levels)
  input wire busWakeEvent,
  input wire overTempCond,
  input wire rxStuckLowCond,
  input wire rxStuckHighCond,
  input wire txDominantCond,
  input wire busDomClampCond,
  input wire overCurrentCond,
  input wire busFailurePendCond,
  input wire busFailureConfCond,
  input wire lowLineBatCond,
  // Transceiver enables
  output reg driverEnable,
  output reg receiverEnable,
  output reg busWakeupReceiverEnabled,
  // Interrupt
  output wire irq,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  wire [NUM_FLAGS-1:0] condRaw;
  reg [NUM_FLAGS-1:0] condMeta_q;
  reg [NUM_FLAGS-1:0] cond_q;
  reg wakePrev_q;

  assign condRaw = {lowLineBatCond, busFailureConfCond, busFailurePendCond, overCurrentCond,
                    busDomClampCond, txDominantCond, rxStuckHighCond, rxStuckLowCond,
                    overTempCond, busWakeEvent};

  always @(posedge sysClk or negedge rst_b) begin
    if (!rst_b) begin
      condMeta_q <= {NUM_FLAGS{1'b0}};
      cond_q <= {NUM_FLAGS{1'b0}};
      wakePrev_q <= 1'b0;
    end else begin
      condMeta_q <= condRaw;
      cond_q <= condMeta_q;
      wakePrev_q <= cond_q[`FLG_WAKE];
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  reg awHeld_q;
  reg [7:0] awAddr_q;
  reg wHeld_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire doWrite;
  reg [2:0] ctrl_q;
  reg [NUM_FLAGS-1:0] irqEn_q;
  reg [NUM_FLAGS-1:0] irqStat_q;
  reg [NUM_FLAGS-1:0] flags_q;
  reg [NUM_FLAGS-1:0] readMask;
  reg readStrobe;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always @(posedge sysClk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr_q)
          `OFS_CTRL, `OFS_FLAGREAD, `OFS_IRQEN, `OFS_IRQCLR: s_axi_bresp <= `RESP_OKAY;
          `OFS_RTSTAT, `OFS_FLAGS, `OFS_IRQSTAT: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control and interrupt enable registers
  // --------------------------------------------------------------------------
  // Full-word reset value, cut to the three control bits on purpose
  localparam [31:0] CTRL_RST_WORD = `CTRL_RST;

  always @(posedge sysClk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST_WORD[2:0];
      irqEn_q <= {NUM_FLAGS{1'b0}};
    end else if (doWrite) begin
      if (wStrb_q[0] && awAddr_q == `OFS_CTRL)
        ctrl_q <= wData_q[2:0];
      if (wStrb_q[0] && awAddr_q == `OFS_IRQEN)
        irqEn_q[7:0] <= wData_q[7:0];
      if (wStrb_q[1] && awAddr_q == `OFS_IRQEN)
        irqEn_q[NUM_FLAGS-1:8] <= wData_q[NUM_FLAGS-1:8];
    end
  end

  // --------------------------------------------------------------------------
  // Real-time transceiver state
  // --------------------------------------------------------------------------
  always @(posedge sysClk or negedge rst_b) begin
    if (!rst_b) begin
      driverEnable <= 1'b0;
      receiverEnable <= 1'b0;
      busWakeupReceiverEnabled <= 1'b1;
    end else begin
      // A TX dominant failure shuts the driver off three cycles after the input (two synchroniser stages and this register); it returns when the input recovers
      driverEnable <= !ctrl_q[`CTRL_RXONLY] && !ctrl_q[`CTRL_SLEEP]
                      && !cond_q[`FLG_TXDOM];
      receiverEnable <= !ctrl_q[`CTRL_SLEEP];
      busWakeupReceiverEnabled <= ctrl_q[`CTRL_WUEN];
    end
  end

  // --------------------------------------------------------------------------
  // Latched flags, one cell per bit
  // --------------------------------------------------------------------------
  // A read at OFS_FLAGREAD clears a bit only if its condition has already gone;
  // a read during the fault leaves it set until a later read.
  reg [NUM_FLAGS-1:0] readArmed_q;
  wire [NUM_FLAGS-1:0] setEvt;
  wire [NUM_FLAGS-1:0] condGone;

  assign setEvt[`FLG_WAKE] = cond_q[`FLG_WAKE] && !wakePrev_q;
  assign setEvt[NUM_FLAGS-1:1] = cond_q[NUM_FLAGS-1:1];
  assign condGone[`FLG_WAKE] = 1'b1;
  assign condGone[NUM_FLAGS-1:1] = ~cond_q[NUM_FLAGS-1:1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi = gi + 1) begin : gFlag
      always @(posedge sysClk or negedge rst_b) begin
        if (!rst_b) begin
          flags_q[gi] <= 1'b0;
          readArmed_q[gi] <= 1'b0;
          irqStat_q[gi] <= 1'b0;
        end else begin
          // Set wins over any clear in the same cycle
          if (setEvt[gi]) begin
            flags_q[gi] <= 1'b1;
          end else if (flags_q[gi] && (readArmed_q[gi] || readMask[gi]) && condGone[gi]) begin
            flags_q[gi] <= 1'b0;
          end
          if (!flags_q[gi] || (setEvt[gi] && !condGone[gi]))
            readArmed_q[gi] <= 1'b0;
          else if (readMask[gi] && flags_q[gi])
            readArmed_q[gi] <= 1'b1;
          if (setEvt[gi] && !flags_q[gi])
            irqStat_q[gi] <= 1'b1;
          else if (doWrite && awAddr_q == `OFS_IRQCLR && wData_q[gi])
            irqStat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irqStat_q & irqEn_q);

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    readStrobe = s_axi_arvalid && s_axi_arready;
    readMask = {NUM_FLAGS{1'b0}};
    if (readStrobe && s_axi_araddr == `OFS_FLAGREAD)
      readMask = {NUM_FLAGS{1'b1}};
  end

  always @(posedge sysClk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (readStrobe) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= {29'h0000_0000, ctrl_q};
        `OFS_RTSTAT: s_axi_rdata <= {29'h0000_0000, busWakeupReceiverEnabled,
                                     receiverEnable, driverEnable};
        `OFS_FLAGS, `OFS_FLAGREAD: s_axi_rdata <= {{(32-NUM_FLAGS){1'b0}}, flags_q};
        `OFS_IRQSTAT: s_axi_rdata <= {{(32-NUM_FLAGS){1'b0}}, irqStat_q};
        `OFS_IRQEN: s_axi_rdata <= {{(32-NUM_FLAGS){1'b0}}, irqEn_q};
        `OFS_IRQCLR: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // can_transceiver_status_flags

// *** common/can_flags_defines.vh ***
// Register map, field positions and reset values of the transceiver flag block
`ifndef CAN_FLAGS_DEFINES_VH
`define CAN_FLAGS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_RTSTAT 8'h04
`define OFS_FLAGS 8'h08
`define OFS_FLAGREAD 8'h0C
`define OFS_IRQSTAT 8'h10
`define OFS_IRQEN 8'h14
`define OFS_IRQCLR 8'h18

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTRL_RXONLY 0
`define CTRL_SLEEP 1
`define CTRL_WUEN 2
`define CTRL_RST 32'h0000_0004

// ----------------------------------------------------------------------------
// Real-time status fields
// ----------------------------------------------------------------------------
`define RT_DRV 0
`define RT_RCV 1
`define RT_WU 2

// ----------------------------------------------------------------------------
// Latched flag fields
// ----------------------------------------------------------------------------
`define FLG_WAKE 0
`define FLG_OTEMP 1
`define FLG_RXLOW 2
`define FLG_RXHIGH 3
`define FLG_TXDOM 4
`define FLG_BUSDOM 5
`define FLG_OCUR 6
`define FLG_PEND 7
`define FLG_CONF 8
`define FLG_LOWBAT 9
`define NFLAGS 10

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** verif/can_flags_chk.sv ***
// Port checks for the transceiver flag block
`timescale 1ns/10ps
`include "can_flags_defines.vh"
module can_flags_chk (
  // Clock, reset and state
  input wire sysClk,
  input wire rst_b,
  input wire txDominantCond,
  input wire driverEnable,
  input wire receiverEnable,
  input wire busWakeupReceiverEnabled,
  // Bus
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (!rst_b);
  // Receiver enable may only fall, and wake-up receiver enable only change, just after a write response
  logic [3:0] sinceB;
  always_ff @(posedge sysClk or negedge rst_b)
    if (!rst_b) sinceB <= 4'hF;
    else if (s_axi_bvalid) sinceB <= 4'h0;
    else if (sinceB != 4'hF) sinceB <= sinceB + 4'h1;
  a_drv_txdom: assert property (txDominantCond [*6] |-> !driverEnable)
    else $error("driver on during tx dominant");
  a_drv_rcv: assert property (!receiverEnable |-> !driverEnable)
    else $error("driver on, receiver off");
  a_rcv_cmd: assert property ($fell(receiverEnable) |-> s_axi_bvalid || sinceB < 4'h4)
    else $error("receiver off without write");
  a_wu_cmd: assert property ($changed(busWakeupReceiverEnabled) |-> s_axi_bvalid || sinceB < 4'h4)
    else $error("wake receiver moved alone");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_IRQCLR
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("bad unmapped");
  c_txdom: cover property (txDominantCond [*6]);
  c_rcv_off: cover property ($fell(receiverEnable));
  c_unmapped: cover property (s_axi_arvalid && s_axi_araddr > `OFS_IRQCLR);
endmodule // can_flags_chk

// *** verif/axi_host.sv ***
// Host model: AXI4-Lite master for register traffic
`timescale 1ns/10ps
module axi_host (
  // Clock
  input wire sysClk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000F;
  end
  // Handshakes are judged at the rising edge that moves them
  task automatic xfer(input logic w, input logic [7:0] a, inout logic [31:0] d,
                      output logic [1:0] r, output logic late);
    logic ta, tw, tr;
    int n;
    @(posedge sysClk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    late = 1'b1;
    for (n = 0; n < 64 && late; n++) begin
      @(posedge sysClk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      late = !(s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready);
      r = w ? s_axi_bresp : s_axi_rresp;
      d = w ? d : s_axi_rdata;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (!late) {s_axi_bready, s_axi_rready} <= 2'h0;
    end
  endtask
endmodule // axi_host

// *** verif/tb_top.sv ***
// Self-checking bench for the transceiver flag block
`timescale 1ns/10ps
`include "can_flags_defines.vh"
module tb_top;
  logic sysClk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] cond = 10'h000;
  wire busWakeEvent, overTempCond, rxStuckLowCond, rxStuckHighCond, txDominantCond;
  wire busDomClampCond, overCurrentCond, busFailurePendCond, busFailureConfCond, lowLineBatCond;
  wire driverEnable, receiverEnable, busWakeupReceiverEnabled, irq;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int cmp_count = 0;
  int i;
  logic [31:0] lfsr = 32'h0000_6121;
  logic [31:0] v;
  assign {lowLineBatCond, busFailureConfCond, busFailurePendCond, overCurrentCond,
    busDomClampCond, txDominantCond, rxStuckHighCond, rxStuckLowCond, overTempCond,
    busWakeEvent} = cond;
  can_transceiver_status_flags u_can_transceiver_status_flags (.*);
  axi_host u_axi_host (.*);
  always #4 sysClk = ~sysClk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rt(input logic [31:0] c, input logic txd);
    return {29'h0000_0000, c[2], ~c[1], ~(c[0] | c[1] | txd)};
  endfunction
  task automatic results;
    $display("Compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = `RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    logic late;
    d = e;
    u_axi_host.xfer(w, a, d, r, late);
    cmp({r, d}, {er, e});
    fails += late;
    if (late) results;
  endtask
  task automatic ci(input logic e);
    @(negedge sysClk);
    cmp({33'h0_0000_0000, irq}, {33'h0_0000_0000, e});
  endtask
  // Conditions pass a two-stage synchroniser, so allow settling time
  task automatic setc(input logic [9:0] c);
    @(posedge sysClk);
    cond <= c;
    repeat (6) @(posedge sysClk);
  endtask
  initial begin
    repeat (5) @(posedge sysClk);
    rst_b <= 1'b1;
    op(1'b0, `OFS_CTRL, `CTRL_RST);
    op(1'b0, `OFS_RTSTAT, 32'h0000_0007);
    op(1'b0, `OFS_RTSTAT, 32'h0000_0007);
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      v = (i < 8) ? i : lfsr & 32'h0000_0007;
      op(1'b1, `OFS_CTRL, v);
      op(1'b0, `OFS_RTSTAT, rt(v, 1'b0));
    end
    op(1'b1, `OFS_CTRL, `CTRL_RST);
    setc(10'h010);
    op(1'b0, `OFS_RTSTAT, rt(`CTRL_RST, 1'b1));
    setc(10'h000);
    op(1'b0, `OFS_FLAGREAD, 32'h0000_0010);
    $display("control test done");
    for (i = 0; i < `NFLAGS; i++) begin
      v = 32'h0000_0001 << i;
      setc(v[9:0]);
      if (i == 0) setc(10'h000);
      op(1'b0, `OFS_FLAGREAD, v);
      op(1'b0, `OFS_FLAGS, (i == 0) ? 32'h0000_0000 : v);
      setc(10'h000);
      op(1'b0, `OFS_FLAGREAD, (i == 0) ? 32'h0000_0000 : v);
      op(1'b0, `OFS_FLAGS, 32'h0000_0000);
    end
    $display("flag test done");
    lfsr = nxt(lfsr);
    v = (lfsr & 32'h0000_03FE) | 32'h0000_0002;
    op(1'b1, `OFS_IRQCLR, 32'h0000_03FF);
    op(1'b1, `OFS_IRQEN, 32'h0000_03FF);
    setc(v[9:0]);
    op(1'b0, `OFS_IRQSTAT, v);
    ci(1'b1);
    op(1'b1, `OFS_IRQEN, 32'h0000_0000);
    ci(1'b0);
    op(1'b1, `OFS_IRQEN, 32'h0000_03FF);
    setc(10'h000);
    op(1'b0, `OFS_FLAGREAD, v);
    op(1'b1, `OFS_IRQCLR, 32'h0000_03FF);
    ci(1'b0);
    op(1'b0, `OFS_IRQSTAT, 32'h0000_0000);
    $display("interrupt test done");
    op(1'b0, 8'h40, 32'h0000_0000, `RESP_SLVERR);
    op(1'b1, `OFS_RTSTAT, 32'h0000_0000);
    op(1'b0, `OFS_RTSTAT, 32'h0000_0007);
    $display("bus test done");
    results;
  end
endmodule // tb_top
bind can_transceiver_status_flags can_flags_chk u_can_flags_chk (.*);
